// ===== verilog/rhs_pkg.sv
// package: constants for the radio host spi pin-control link
//
// Overview of operation
// - host frames transfers with select held low
// - data enters on master-out line, also shared line
// - three-wire option frees master-in pin as gpio
// - master-in floats when select high, four-wire mode
// - interrupt pin polarity selectable, or gpio
// - divided crystal clock out, or gpio
// - clock-out pin floats in sleep, except in gpio mode
// - active-high reset held from power-up until host clears it
// - spi clock never above 4 mhz
// - spi port works during sleep
package rhs_pkg;
  // system clock and serial clock limit
  localparam int CLK_KHZ = 125000;
  localparam int SPI_MAX_KHZ = 4000;
  localparam int SCK_HALF_CYC = (CLK_KHZ + 2 * SPI_MAX_KHZ - 1) / (2 * SPI_MAX_KHZ);
  // serial command byte: bit 7 write, bits 6:0 address
  localparam int CMD_WR_BIT = 7;
  localparam logic [6:0] ADR_CFG = 7'h01;
  localparam logic [6:0] ADR_GPIO = 7'h02;
  localparam logic [6:0] ADR_STAT = 7'h03;
  localparam logic [6:0] ADR_SLEEP = 7'h04;
  localparam logic [6:0] ADR_PINS = 7'h05;
  // device configuration fields
  localparam int CFG_3W = 0;
  localparam int CFG_IRQ_POL = 1;
  localparam int CFG_IRQ_GPIO = 2;
  localparam int CFG_CKO_GPIO = 3;
  localparam int CFG_CKO_SEL = 4;
  localparam logic [7:0] CFG_RST = 8'h02;
  // gpio register: outputs bits 2:0, enables bits 6:4
  localparam int PIN_IRQ = 0;
  localparam int PIN_MISO = 1;
  localparam int PIN_CKO = 2;
  localparam int GPIO_OE_LSB = 4;
  localparam logic [7:0] GPIO_RST = 8'h00;
  localparam logic [7:0] SLEEP_RST = 8'h00;
  // clock-out selections, 12 mhz crystal
  localparam logic [2:0] CKO_12M = 3'h0;
  localparam logic [2:0] CKO_6M = 3'h1;
  localparam logic [2:0] CKO_3M = 3'h2;
  localparam logic [2:0] CKO_1M5 = 3'h3;
  localparam logic [2:0] CKO_0M75 = 3'h4;
  // host controller registers on ahb-lite
  localparam logic [3:0] HA_DATA = 4'h0;
  localparam logic [3:0] HA_CFG = 4'h4;
  localparam logic [3:0] HA_STAT = 4'h8;
  localparam int HC_3W = 0;
  localparam int HC_RST = 1;
  localparam int HC_IRQ_POL = 2;
  localparam logic [2:0] HCFG_RST = 3'h6;
  localparam int HS_BUSY = 0;
  localparam int HS_IRQ = 1;
  // host engine states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN = 3'b010,
    S_END = 3'b100
  } rhs_state_e;
endpackage

// ===== verilog/rhs_if.sv
// interface: pins between host controller and radio device
`timescale 1ns/1ps
interface rhs_if;
  logic ss_n;
  logic sck;
  logic rst;
  logic mosi_h_o;
  logic mosi_h_oe;
  logic mosi_d_o;
  logic mosi_d_oe;
  logic miso_o;
  logic miso_oe;
  logic irq_o;
  logic irq_oe;
  logic cko_o;
  logic cko_oe;
  logic mosi_w;
  logic miso_w;
  logic irq_w;
  logic cko_w;
  // resolved wire levels, weak pull-up on data, pull-down elsewhere
  assign mosi_w = mosi_h_oe ? mosi_h_o : (mosi_d_oe ? mosi_d_o : 1'b1);
  assign miso_w = miso_oe ? miso_o : 1'b1;
  assign irq_w = irq_oe ? irq_o : 1'b0;
  assign cko_w = cko_oe ? cko_o : 1'b0;
  modport dev(input ss_n, sck, rst, mosi_w, miso_w, irq_w, cko_w,
              output mosi_d_o, mosi_d_oe, miso_o, miso_oe, irq_o, irq_oe, cko_o, cko_oe);
  modport host(output ss_n, sck, rst, mosi_h_o, mosi_h_oe,
               input mosi_w, miso_w, irq_w);
endinterface

// ===== verilog/rhs_dev.sv
// device end: spi slave registers, interrupt pin, clock-out pin
`timescale 1ns/1ps
module rhs_dev #(
  parameter int DIV_W = 4
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic XTAL_I,
  input wire logic IRQ_EVT_I,
  output logic SLEEP_O,
  output logic [7:0] CFG_O,
  rhs_if.dev LINK
);
  import rhs_pkg::*;

  logic rst_a;
  logic [2:0] ss_s;
  logic [2:0] sck_s;
  logic [1:0] mosi_s;
  logic [2:0] xt_s;
  logic [5:0] pin_s;
  logic ss_act;
  logic sck_rise;
  logic sck_fall;
  logic din;
  logic [4:0] cnt_r;
  logic [6:0] rx_r;
  logic [7:0] cmd_r;
  logic [7:0] tx_r;
  logic out_r;
  logic drv_r;
  logic [7:0] cfg_r;
  logic [7:0] gpio_r;
  logic [7:0] sleep_r;
  logic [DIV_W-1:0] div_r;
  logic cko_r;
  logic irq_r;
  logic [7:0] rd_val;
  logic [6:0] rd_adr;
  logic three_w;

  // reset from the pin or the local system reset
  assign rst_a = RST_I | LINK.rst;

  // two-flop synchronisers, third stage only for edges
  always_ff @(posedge CLK_I or posedge rst_a) begin
    if (rst_a) begin
      ss_s <= 3'h7;
      sck_s <= 3'h0;
      mosi_s <= 2'h0;
      xt_s <= 3'h0;
    end else if (CE_I) begin
      ss_s <= {ss_s[1:0], LINK.ss_n};
      sck_s <= {sck_s[1:0], LINK.sck};
      mosi_s <= {mosi_s[0], LINK.mosi_w};
      xt_s <= {xt_s[1:0], XTAL_I};
    end
  end

  // pin level readback synchronisers: irq, miso, cko
  always_ff @(posedge CLK_I or posedge rst_a) begin
    if (rst_a) begin
      pin_s <= 6'h00;
    end else if (CE_I) begin
      pin_s <= {pin_s[2:0], LINK.cko_w, LINK.miso_w, LINK.irq_w};
    end
  end

  // frame and edge detection
  assign ss_act = ~ss_s[1];
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign din = mosi_s[1];
  assign three_w = cfg_r[CFG_3W];
  assign rd_adr = {rx_r[5:0], din};

  // read mux for the byte after a read command
  always_comb begin
    case (rd_adr)
      ADR_CFG: rd_val = cfg_r;
      ADR_GPIO: rd_val = gpio_r;
      ADR_STAT: rd_val = {6'h00, sleep_r[0], IRQ_EVT_I};
      ADR_SLEEP: rd_val = sleep_r;
      ADR_PINS: rd_val = {5'h00, pin_s[5:3]};
      default: rd_val = 8'h00;
    endcase
  end

  // bit counter and input shifter, never gated by sleep
  always_ff @(posedge CLK_I or posedge rst_a) begin
    if (rst_a) begin
      cnt_r <= 5'h00;
      rx_r <= 7'h00;
      cmd_r <= 8'h00;
    end else if (CE_I) begin
      if (!ss_act) begin
        cnt_r <= 5'h00;
      end else if (sck_rise) begin
        rx_r <= {rx_r[5:0], din};
        if (cnt_r != 5'h10) begin
          cnt_r <= cnt_r + 5'h01;
        end
        if (cnt_r == 5'h07) begin
          cmd_r <= {rx_r, din};
        end
      end
    end
  end

  // output shifter: load after command, shift on falling edges
  always_ff @(posedge CLK_I or posedge rst_a) begin
    if (rst_a) begin
      tx_r <= 8'h00;
      out_r <= 1'b0;
      drv_r <= 1'b0;
    end else if (CE_I) begin
      if (!ss_act) begin
        out_r <= 1'b0;
        drv_r <= 1'b0;
      end else if (sck_rise && cnt_r == 5'h07) begin
        tx_r <= rd_val;
      end else if (sck_fall && cnt_r >= 5'h08 && cnt_r < 5'h10) begin
        out_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
        drv_r <= 1'b1;
      end
    end
  end

  // register writes on the last rising edge of the data byte
  always_ff @(posedge CLK_I or posedge rst_a) begin
    if (rst_a) begin
      cfg_r <= CFG_RST;
      gpio_r <= GPIO_RST;
      sleep_r <= SLEEP_RST;
    end else if (CE_I) begin
      if (ss_act && sck_rise && cnt_r == 5'h0f && cmd_r[CMD_WR_BIT]) begin
        case (cmd_r[6:0])
          ADR_CFG: cfg_r <= {rx_r, din};
          ADR_GPIO: gpio_r <= {rx_r, din};
          ADR_SLEEP: sleep_r <= {rx_r, din};
          default: ;
        endcase
      end
    end
  end

  // crystal divider, counts crystal rising edges
  always_ff @(posedge CLK_I or posedge rst_a) begin
    if (rst_a) begin
      div_r <= '0;
    end else if (CE_I && xt_s[1] && !xt_s[2]) begin
      div_r <= div_r + 1'b1;
    end
  end

  // clock-out frequency select
  always_ff @(posedge CLK_I or posedge rst_a) begin
    if (rst_a) begin
      cko_r <= 1'b0;
    end else if (CE_I) begin
      case (cfg_r[CFG_CKO_SEL +: 3])
        CKO_12M: cko_r <= xt_s[1];
        CKO_6M: cko_r <= div_r[0];
        CKO_3M: cko_r <= div_r[1];
        CKO_1M5: cko_r <= div_r[2];
        CKO_0M75: cko_r <= div_r[3];
        default: cko_r <= 1'b0;
      endcase
    end
  end

  // interrupt level with selected polarity
  always_ff @(posedge CLK_I or posedge rst_a) begin
    if (rst_a) begin
      irq_r <= 1'b0;
    end else if (CE_I) begin
      irq_r <= cfg_r[CFG_IRQ_POL] ? IRQ_EVT_I : ~IRQ_EVT_I;
    end
  end

  // master-in pin: spi data, or gpio in three-wire mode
  assign LINK.miso_o = three_w ? gpio_r[PIN_MISO] : out_r;
  assign LINK.miso_oe = three_w ? gpio_r[GPIO_OE_LSB + PIN_MISO] : ss_act;

  // shared data line driven back only in the data byte of a read
  assign LINK.mosi_d_o = out_r;
  assign LINK.mosi_d_oe = three_w & ss_act & drv_r & ~cmd_r[CMD_WR_BIT];

  // interrupt pin: polarity-steered event, or gpio
  assign LINK.irq_o = cfg_r[CFG_IRQ_GPIO] ? gpio_r[PIN_IRQ] : irq_r;
  assign LINK.irq_oe = cfg_r[CFG_IRQ_GPIO] ? gpio_r[GPIO_OE_LSB + PIN_IRQ] : 1'b1;

  // clock-out pin: divided clock floats in sleep, gpio keeps driving
  assign LINK.cko_o = cfg_r[CFG_CKO_GPIO] ? gpio_r[PIN_CKO] : cko_r;
  assign LINK.cko_oe = cfg_r[CFG_CKO_GPIO] ? gpio_r[GPIO_OE_LSB + PIN_CKO]
                                          : ~sleep_r[0];

  // user-side status
  assign SLEEP_O = sleep_r[0];
  assign CFG_O = cfg_r;
endmodule

// ===== verilog/rhs_host.sv
// host end: ahb-lite controlled spi master for the radio pins
`timescale 1ns/1ps
module rhs_host #(
  parameter int HALF_CYC = rhs_pkg::SCK_HALF_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  rhs_if.host LINK
);
  import rhs_pkg::*;

  localparam logic [7:0] HC_LAST = 8'(HALF_CYC - 1);

  rhs_state_e st_r;
  logic take;
  logic wr_r;
  logic [3:0] wa_r;
  logic [31:0] hrdata_r;
  logic [2:0] cfg_r;
  logic [7:0] rd_r;
  logic wcmd_r;
  logic go;
  logic [15:0] sh_r;
  logic [15:0] rxs_r;
  logic [7:0] hc_r;
  logic [5:0] ph_r;
  logic ss_n_r;
  logic sck_r;
  logic mo_r;
  logic moe_r;
  logic [1:0] miso_s;
  logic [1:0] mosi_s;
  logic [1:0] irq_s;
  logic busy;
  logic irq_act;
  logic din;
  logic half_end;

  // address phase capture, zero wait states
  assign take = HSEL_I & HREADY_I & HTRANS_I[1];
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign HRDATA_O = hrdata_r;
  assign busy = (st_r != S_IDLE);
  assign irq_act = cfg_r[HC_IRQ_POL] ? irq_s[1] : ~irq_s[1];
  assign go = wr_r && wa_r == HA_DATA && !busy;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wr_r <= 1'b0;
      wa_r <= 4'h0;
      hrdata_r <= 32'h0;
    end else if (CE_I) begin
      wr_r <= take & HWRITE_I;
      wa_r <= HADDR_I[3:0];
      if (take && !HWRITE_I) begin
        case (HADDR_I[3:0])
          HA_DATA: hrdata_r <= {24'h0, rd_r};
          HA_CFG: hrdata_r <= {29'h0, cfg_r};
          HA_STAT: hrdata_r <= {30'h0, irq_act, busy};
          default: hrdata_r <= 32'h0;
        endcase
      end
    end
  end

  // configuration write; reset pin starts asserted
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cfg_r <= HCFG_RST;
    end else if (CE_I && wr_r && wa_r == HA_CFG) begin
      cfg_r <= HWDATA_I[2:0];
    end
  end

  // pin synchronisers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      miso_s <= 2'h0;
      mosi_s <= 2'h0;
      irq_s <= 2'h0;
    end else if (CE_I) begin
      miso_s <= {miso_s[0], LINK.miso_w};
      mosi_s <= {mosi_s[0], LINK.mosi_w};
      irq_s <= {irq_s[0], LINK.irq_w};
    end
  end

  assign din = cfg_r[HC_3W] ? mosi_s[1] : miso_s[1];
  assign half_end = (hc_r == HC_LAST);

  // serial engine: 16 bits, half periods of HALF_CYC cycles
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_r <= S_IDLE;
      sh_r <= 16'h0;
      rxs_r <= 16'h0;
      rd_r <= 8'h0;
      hc_r <= 8'h0;
      ph_r <= 6'h0;
      ss_n_r <= 1'b1;
      sck_r <= 1'b0;
      mo_r <= 1'b0;
      moe_r <= 1'b0;
      wcmd_r <= 1'b0;
    end else if (CE_I) begin
      hc_r <= (busy && !half_end) ? hc_r + 8'h1 : 8'h0;
      case (st_r)
        S_IDLE: begin
          if (go) begin
            st_r <= S_RUN;
            sh_r <= HWDATA_I[15:0];
            ph_r <= 6'h0;
            ss_n_r <= 1'b0;
            mo_r <= HWDATA_I[15];
            // write flag kept whole, the shifter loses it after the first bit
            wcmd_r <= HWDATA_I[8 + CMD_WR_BIT];
            moe_r <= 1'b1;
          end
        end
        S_RUN: begin
          if (half_end) begin
            ph_r <= ph_r + 6'h1;
            sck_r <= ~ph_r[0];
            if (ph_r[0]) begin
              rxs_r <= {rxs_r[14:0], din};
              sh_r <= {sh_r[14:0], 1'b0};
              mo_r <= sh_r[14];
              if (ph_r == 6'h0f && cfg_r[HC_3W] && !wcmd_r) begin
                moe_r <= 1'b0;
              end
              if (ph_r == 6'h1f) begin
                st_r <= S_END;
                rd_r <= {rxs_r[6:0], din};
              end
            end
          end
        end
        S_END: begin
          if (half_end) begin
            moe_r <= 1'b0;
            if (!ss_n_r) begin
              ss_n_r <= 1'b1;
            end else begin
              st_r <= S_IDLE;
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  assign LINK.ss_n = ss_n_r;
  assign LINK.sck = sck_r;
  assign LINK.rst = cfg_r[HC_RST];
  assign LINK.mosi_h_o = mo_r;
  assign LINK.mosi_h_oe = moe_r;
endmodule

// ===== dv/rhs_assertions.sv
// checker: link pin timing and reset-state assertions
`timescale 1ns/1ps
module rhs_assertions (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic ss_n,
  input wire logic sck,
  input wire logic rst,
  input wire logic mosi_w,
  input wire logic miso_w,
  input wire logic miso_oe,
  input wire logic mosi_d_oe,
  input wire logic cko_o,
  input wire logic cko_oe
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic [9:0] low_cnt_r;
  // length of the current select-low stretch
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      low_cnt_r <= 10'h000;
    end else if (ss_n) begin
      low_cnt_r <= 10'h000;
    end else begin
      low_cnt_r <= low_cnt_r + 10'h001;
    end
  end
  // half periods of the serial clock
  sequence s_half_hi;
    sck [*8];
  endsequence
  sequence s_half_lo;
    !sck [*8];
  endsequence
  a_sck_idle_low: assert property (ss_n |-> !sck)
    else $error("serial clock high outside a frame");
  a_sck_hi_width: assert property ($rose(sck) |-> s_half_hi)
    else $error("serial clock high phase too short");
  a_sck_lo_width: assert property (($fell(sck) && !ss_n) |-> s_half_lo)
    else $error("serial clock low phase too short");
  a_frame_length: assert property ($rose(ss_n) |-> (low_cnt_r >= 10'h200 && low_cnt_r <= 10'h220))
    else $error("select low for wrong length");
  a_select_gap: assert property ($rose(ss_n) |-> ss_n [*8])
    else $error("select gap too short");
  a_mosi_hold_hi: assert property ((!ss_n && sck && $past(sck)) |-> $stable(mosi_w))
    else $error("shared data moved while clock high");
  a_miso_hold_hi: assert property ((!ss_n && sck && $past(sck) && miso_oe && $past(miso_oe))
    |-> $stable(miso_w))
    else $error("return data moved while clock high");
  a_dev_rst_quiet: assert property ((rst && $past(rst)) |->
    (!miso_oe && !mosi_d_oe && cko_oe && !cko_o))
    else $error("device pins active in reset");
endmodule

// ===== dv/tb_top.sv
// testbench: host and device joined over the link, driven over ahb-lite
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
  import rhs_pkg::*;
  logic clk, rst, xtal, evt, hsel, hwrite, hreadyout, hresp, sleep;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] cfg, q;
  int fails = 0;
  int n_compared = 0;
  rhs_if u_rhs_if();
  rhs_host u_rhs_host(.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .LINK(u_rhs_if.host));
  rhs_dev u_rhs_dev(.CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .XTAL_I(xtal), .IRQ_EVT_I(evt),
    .SLEEP_O(sleep), .CFG_O(cfg), .LINK(u_rhs_if.dev));
  rhs_assertions u_rhs_assertions(.CLK_I(clk), .RST_I(rst), .ss_n(u_rhs_if.ss_n),
    .sck(u_rhs_if.sck), .rst(u_rhs_if.rst), .mosi_w(u_rhs_if.mosi_w),
    .miso_w(u_rhs_if.miso_w), .miso_oe(u_rhs_if.miso_oe), .mosi_d_oe(u_rhs_if.mosi_d_oe),
    .cko_o(u_rhs_if.cko_o), .cko_oe(u_rhs_if.cko_oe));
  // system clock and 12 mhz crystal
  always #4 clk = ~clk;
  always #41.667 xtal = ~xtal;
  task end_of_test;
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one single-word transfer, address phase then data phase
  task ahb(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0, a};
    hwrite <= w;
    for (int p = 0; p < 2; p++) begin
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
        n++;
        if (n > 100) begin
          fails++;
          end_of_test();
        end
        @(posedge clk);
      end
      if (p == 0) begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
      end
    end
    rd = hrdata;
  endtask
  // one two-byte serial transfer, polled until idle
  task spi(input logic [7:0] c, input logic [7:0] d, output logic [7:0] o);
    int n;
    n = 0;
    ahb(1'b1, HA_DATA, {16'h0, c, d}, r);
    r = 32'h1;
    while (r[HS_BUSY] !== 1'b0) begin
      n++;
      if (n > 400) begin
        fails++;
        end_of_test();
      end
      ahb(1'b0, HA_STAT, 32'h0, r);
    end
    ahb(1'b0, HA_DATA, 32'h0, r);
    o = r[7:0];
  endtask
  task t_reset;
    ahb(1'b0, HA_CFG, 32'h0, r);
    `CHK("host cfg", {29'h0, HCFG_RST}, r)
    `CHK("hresp okay", 1'b0, hresp)
    ahb(1'b1, HA_CFG, 32'h0, r);
    spi({1'b0, ADR_CFG}, 8'h00, q);
    `CHK("dev cfg", CFG_RST, q)
    `CHK("cfg port", CFG_RST, cfg)
    `CHK("miso idle oe", 1'b0, u_rhs_if.miso_oe)
  endtask
  task t_irq;
    spi({1'b1, ADR_CFG}, 8'h02, q);
    evt <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("irq high pol", 1'b1, u_rhs_if.irq_w)
    spi({1'b1, ADR_CFG}, 8'h00, q);
    repeat (8) @(posedge clk);
    `CHK("irq low pol", 1'b0, u_rhs_if.irq_w)
    ahb(1'b0, HA_STAT, 32'h0, r);
    `CHK("host irq stat", 2'b10, r[1:0])
    evt <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("irq low idle", 1'b1, u_rhs_if.irq_w)
  endtask
  // count clock-out rises for each divider setting
  task t_cko;
    int n, e;
    logic pv;
    for (int s = 0; s < 5; s++) begin
      spi({1'b1, ADR_CFG}, {1'b0, s[2:0], 4'h0}, q);
      repeat (20) @(posedge clk);
      n = 0;
      e = 96 >> s;
      pv = u_rhs_if.cko_w;
      // sample on the falling edge, away from the launching edge
      repeat (1000) begin
        @(negedge clk);
        if (u_rhs_if.cko_w === 1'b1 && pv === 1'b0) n++;
        pv = u_rhs_if.cko_w;
      end
      `CHK("cko rises", 1'b1, (n + 1 >= e && n <= e + 1))
    end
  endtask
  task t_sleep;
    spi({1'b1, ADR_SLEEP}, 8'h01, q);
    repeat (4) @(posedge clk);
    `CHK("sleep port", 1'b1, sleep)
    `CHK("cko float", 1'b0, u_rhs_if.cko_oe)
    // gpio mode while asleep: cko driven low, irq driven high
    spi({1'b1, ADR_GPIO}, 8'h51, q);
    spi({1'b1, ADR_CFG}, 8'h0c, q);
    repeat (4) @(posedge clk);
    `CHK("cko gpio oe", 1'b1, u_rhs_if.cko_oe)
    `CHK("cko gpio low", 1'b0, u_rhs_if.cko_w)
    `CHK("irq gpio lvl", 1'b1, u_rhs_if.irq_w)
    spi({1'b0, ADR_STAT}, 8'h00, q);
    `CHK("stat sleep", 1'b1, q[1])
    `CHK("stat evt", 1'b0, q[0])
    spi({1'b1, ADR_SLEEP}, 8'h00, q);
    `CHK("sleep clear", 1'b0, sleep)
  endtask
  task t_3w;
    spi({1'b1, ADR_CFG}, 8'h01, q);
    ahb(1'b1, HA_CFG, 32'h1, r);
    spi({1'b0, ADR_CFG}, 8'h00, q);
    `CHK("3w readback", 8'h01, q)
    spi({1'b1, ADR_GPIO}, 8'h22, q);
    repeat (4) @(posedge clk);
    `CHK("miso gpio oe", 1'b1, u_rhs_if.miso_oe)
    `CHK("miso gpio lvl", 1'b1, u_rhs_if.miso_o)
    spi({1'b0, ADR_PINS}, 8'h00, q);
    `CHK("pins irq miso", 2'b11, q[1:0])
  endtask
  // main sequence
  initial begin
    clk = 1'b0;
    xtal = 1'b0;
    rst = 1'b1;
    evt = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_irq();
    t_cko();
    t_sleep();
    t_3w();
    end_of_test();
  end
endmodule
